/* File: src/refresh_timer.sv */
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module refresh_timer
  import refresh_pkg::*;
#(
  parameter int DIV_W = refresh_pkg::PRESCALE_W
) (
  input  wire logic              core_clk,        // system clock
  input  wire logic              sys_rst,         // power-on reset, sync
  input  wire logic              clk_en,          // freeze when low
  input  wire logic              hw_standby_pin,  // standby pin, async
  input  wire logic              normal_mode,     // 64-kbyte mode
  input  refresh_pkg::wb_req_t   wb_i,            // wishbone request
  output logic [31:0]            wb_dat_o,        // wishbone read data
  output logic                   wb_ack_o,        // wishbone ack
  output logic                   refresh_req,     // refresh bus request
  input  wire logic              refresh_grant,   // bus granted
  output logic                   refresh_self_ff, // self refresh active
  output logic                   cas_n_ff,        // column strobe
  output logic                   ras_n_ff,        // row strobe
  output logic                   match_interrupt  // compare-match irq
);

  // ==========================================================
  // standby synchroniser
  logic stby_meta_ff;
  logic stby_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stby_meta_ff <= 1'b0;
      stby_ff      <= 1'b0;
    end else if (clk_en) begin
      stby_meta_ff <= hw_standby_pin;
      stby_ff      <= stby_meta_ff;
    end
  end

  // power-on reset and hardware standby act alike
  logic init;
  assign init = sys_rst | stby_ff;

  // ==========================================================
  // wishbone slave
  logic        ack_ff;
  logic [31:0] rd_ff;
  logic        req;
  logic        fire;
  logic        wr;
  logic        take;
  logic        wr_control;
  logic        wr_count;
  logic        wr_period;
  logic        wr_wait;
  logic        rd_control;

  assign req      = wb_i.cyc & wb_i.stb;
  assign fire     = req & ack_ff;
  assign wr       = fire & wb_i.we & wb_i.sel[0];
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  // reads are taken before ack, writes land with ack
  assign take       = req & ~ack_ff;
  assign wr_control = wr & hit(wb_i.adr, ADDR_CONTROL);
  assign wr_count   = wr & hit(wb_i.adr, ADDR_COUNT);
  assign wr_period  = wr & hit(wb_i.adr, ADDR_PERIOD);
  assign wr_wait    = wr & hit(wb_i.adr, ADDR_WAIT);
  assign rd_control = take & ~wb_i.we & hit(wb_i.adr, ADDR_CONTROL);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ==========================================================
  // registers
  control_t   ctl_ff;
  logic [7:0] count_ff;
  logic [7:0] period_ff;
  logic [1:0] wait_ff;
  logic       armed_ff;
  logic       tick;
  logic       tick_raw;
  logic       match;
  logic [2:0] clk_sel;
  logic       refreshing;

  assign clk_sel    = {ctl_ff.count_clock_sel_hi, ctl_ff.count_clock_sel_mid, ctl_ff.count_clock_sel_lo};
  assign refreshing = ctl_ff.refresh_ctrl_enable & ~normal_mode;
  assign match      = tick & (count_ff == period_ff);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_ff <= '0;
    end else if (clk_en) begin
      if (req & ~ack_ff) begin
        if (hit(wb_i.adr, ADDR_CONTROL)) begin
          rd_ff <= {24'h0, ctl_ff};
        end else if (hit(wb_i.adr, ADDR_COUNT)) begin
          rd_ff <= {24'h0, count_ff};
        end else if (hit(wb_i.adr, ADDR_PERIOD)) begin
          rd_ff <= {24'h0, period_ff};
        end else if (hit(wb_i.adr, ADDR_WAIT)) begin
          rd_ff <= {30'h0, wait_ff};
        end else begin
          rd_ff <= '0;
        end
      end
    end
  end

  // control register: everything but the flag
  always_ff @(posedge core_clk) begin
    if (init) begin
      ctl_ff.refresh_ctrl_enable     <= CONTROL_RST[CTL_ENABLE];
      ctl_ff.row_column_refresh_wait <= CONTROL_RST[CTL_RCW];
      ctl_ff.refresh_kind_select     <= CONTROL_RST[CTL_KIND];
      ctl_ff.match_irq_enable        <= CONTROL_RST[CTL_IRQEN];
      {ctl_ff.count_clock_sel_hi, ctl_ff.count_clock_sel_mid, ctl_ff.count_clock_sel_lo} <= CONTROL_RST[2:0];
    end else if (clk_en) begin
      if (wr_control) begin
        ctl_ff.refresh_ctrl_enable     <= wb_i.dat[CTL_ENABLE];
        ctl_ff.row_column_refresh_wait <= wb_i.dat[CTL_RCW];
        ctl_ff.refresh_kind_select     <= wb_i.dat[CTL_KIND];
        ctl_ff.match_irq_enable        <= wb_i.dat[CTL_IRQEN] & ~wb_i.dat[CTL_ENABLE];
        {ctl_ff.count_clock_sel_hi, ctl_ff.count_clock_sel_mid, ctl_ff.count_clock_sel_lo} <= wb_i.dat[2:0];
      end else if (ctl_ff.refresh_ctrl_enable) begin
        ctl_ff.match_irq_enable <= 1'b0;
      end
    end
  end

  // match flag: a set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (init) begin
      ctl_ff.match_flag <= CONTROL_RST[CTL_FLAG];
    end else if (clk_en) begin
      if (match) begin
        ctl_ff.match_flag <= 1'b1;
      end else if (wr_control && !wb_i.dat[CTL_FLAG] && armed_ff) begin
        ctl_ff.match_flag <= 1'b0;
      end
    end
  end

  // clear is armed by a read that saw the flag at one
  always_ff @(posedge core_clk) begin
    if (init) begin
      armed_ff <= 1'b0;
    end else if (clk_en) begin
      if (!ctl_ff.match_flag) begin
        armed_ff <= 1'b0;
      end else if (rd_control) begin
        armed_ff <= 1'b1;
      end
    end
  end

  refresh_prescaler #(
    .WIDTH (DIV_W)
  ) u_prescaler (
    .core_clk (core_clk),
    .sys_rst  (init),
    .clk_en   (clk_en),
    .sel      (clk_sel),
    .tick_ff  (tick_raw)
  );

  // the prescaler tick lags the select by a cycle; a stop must bite at once
  assign tick = tick_raw & (clk_sel != SEL_STOP);

  // counter: software write, then match clear, then count
  always_ff @(posedge core_clk) begin
    if (init) begin
      count_ff <= COUNT_RST;
    end else if (clk_en) begin
      if (wr_count) begin
        count_ff <= wb_i.dat[7:0];
      end else if (match) begin
        count_ff <= COUNT_RST;
      end else if (tick) begin
        count_ff <= count_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      period_ff <= PERIOD_RST;
    end else if (clk_en && wr_period) begin
      period_ff <= wb_i.dat[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      wait_ff <= WAIT_RST;
    end else if (clk_en && wr_wait) begin
      wait_ff <= wb_i.dat[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      match_interrupt <= 1'b0;
    end else if (clk_en) begin
      match_interrupt <= ctl_ff.match_flag & ctl_ff.match_irq_enable & ~ctl_ff.refresh_ctrl_enable;
    end
  end

  // ==========================================================
  // refresh sequencer
  refresh_state_t state_ff;
  refresh_state_t nxt_state;
  logic           pending_ff;
  logic [1:0]     wcnt_ff;

  assign refresh_req = (state_ff == RF_REQ);

  // a match while a cycle runs is kept and served after it
  always_ff @(posedge core_clk) begin
    if (init) begin
      pending_ff <= 1'b0;
    end else if (clk_en) begin
      if (match && refreshing) begin
        pending_ff <= 1'b1;
      end else if (state_ff == RF_IDLE) begin
        pending_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RF_IDLE: begin
        if (pending_ff && refreshing) begin
          nxt_state = RF_REQ;
        end
      end
      RF_REQ: begin
        if (refresh_grant) begin
          nxt_state = RF_CAS;
        end
      end
      RF_CAS: begin
        if (ctl_ff.row_column_refresh_wait) begin
          nxt_state = RF_RCW;
        end else begin
          nxt_state = RF_RAS;
        end
      end
      RF_RCW: begin
        nxt_state = RF_RAS;
      end
      RF_RAS: begin
        if (ctl_ff.refresh_kind_select) begin
          nxt_state = RF_SELF;
        end else if (wait_ff != WAIT_RST) begin
          nxt_state = RF_WAIT;
        end else begin
          nxt_state = RF_PRE;
        end
      end
      RF_WAIT: begin
        if (wcnt_ff == wait_ff) begin
          nxt_state = RF_PRE;
        end
      end
      RF_SELF: begin
        if (!refreshing || !ctl_ff.refresh_kind_select) begin
          nxt_state = RF_PRE;
        end
      end
      RF_PRE: begin
        nxt_state = RF_IDLE;
      end
      default: begin
        nxt_state = RF_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      state_ff <= RF_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // wait states count from one; the external wait pin plays no part
  always_ff @(posedge core_clk) begin
    if (init) begin
      wcnt_ff <= WAIT_FIRST;
    end else if (clk_en) begin
      if (state_ff == RF_WAIT) begin
        wcnt_ff <= wcnt_ff + 2'h1;
      end else begin
        wcnt_ff <= WAIT_FIRST;
      end
    end
  end

  // ==========================================================
  // memory strobes, launched from the next state so they meet it
  function automatic logic cas_active(input refresh_state_t s);
    cas_active = (s inside {RF_CAS, RF_RCW, RF_RAS, RF_WAIT, RF_SELF});
  endfunction : cas_active

  function automatic logic ras_active(input refresh_state_t s);
    ras_active = (s inside {RF_RAS, RF_WAIT, RF_SELF});
  endfunction : ras_active

  always_ff @(posedge core_clk) begin
    if (init) begin
      cas_n_ff <= 1'b1;
    end else if (clk_en) begin
      cas_n_ff <= !cas_active(nxt_state);
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      ras_n_ff <= 1'b1;
    end else if (clk_en) begin
      ras_n_ff <= !ras_active(nxt_state);
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      refresh_self_ff <= 1'b0;
    end else if (clk_en) begin
      refresh_self_ff <= (nxt_state == RF_SELF);
    end
  end

endmodule : refresh_timer

/* File: inc/refresh_pkg.sv */
// Behaviour
// - control register zero on power-on, standby
// - enable bit selects refresh or interval timer
// - normal address mode forbids all refresh
// - row-column wait adds one state
// - kind bit picks normal or self refresh
// - counter equal period sets match flag
// - flag clears by read-one then write-zero
// - irq enable gates the match interrupt
// - irq enable forced zero while refreshing
// - select picks stop or seven divided clocks
// - counting starts on nonzero select, halts zero
// - eight-bit counter, one step per tick
// - match clears counter; period is value plus one
// - match with enable starts one refresh
// - match with irq enable raises interrupt
// - counter zero on power-on, standby
// - period all ones on power-on, standby
// - wait field adds zero to three states
package refresh_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT   = 4'h4;
  localparam logic [3:0] ADDR_PERIOD  = 4'h8;
  localparam logic [3:0] ADDR_WAIT    = 4'hC;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST  = 8'hFF;
  localparam logic [1:0] WAIT_RST    = 2'h0;
  localparam logic [1:0] WAIT_FIRST  = 2'h1;

  // ==========================================================
  // control register fields
  localparam int CTL_ENABLE = 7;
  localparam int CTL_RCW    = 6;
  localparam int CTL_KIND   = 5;
  localparam int CTL_FLAG   = 4;
  localparam int CTL_IRQEN  = 3;

  typedef struct packed {
    logic       refresh_ctrl_enable;
    logic       row_column_refresh_wait;
    logic       refresh_kind_select;
    logic       match_flag;
    logic       match_irq_enable;
    logic       count_clock_sel_hi;
    logic       count_clock_sel_mid;
    logic       count_clock_sel_lo;
  } control_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // ==========================================================
  // prescaler taps: log2 of each divisor, select 1 to 7
  localparam int PRESCALE_W = 12;
  localparam logic [2:0] SEL_STOP = 3'h0;
  localparam int TAP_LOG2 [8] = '{0, 1, 3, 5, 7, 9, 11, 12};

  typedef enum {
    RF_IDLE, RF_REQ, RF_CAS, RF_RCW, RF_RAS, RF_WAIT, RF_PRE, RF_SELF
  } refresh_state_t;

endpackage : refresh_pkg

/* File: src/refresh_prescaler.sv */
`timescale 1ns/100ps
module refresh_prescaler
  import refresh_pkg::*;
#(
  parameter int WIDTH = refresh_pkg::PRESCALE_W
) (
  input  wire logic       core_clk,  // system clock
  input  wire logic       sys_rst,   // sync reset
  input  wire logic       clk_en,    // freeze when low
  input  wire logic [2:0] sel,       // divider select
  output logic            tick_ff    // one-cycle tick
);

  logic [WIDTH-1:0] div_ff;

  // mask of low bits that must all be one for a tap tick
  function automatic logic [WIDTH-1:0] tap_mask(input logic [2:0] s);
    tap_mask = (WIDTH'(1) << TAP_LOG2[s]) - WIDTH'(1);
  endfunction : tap_mask

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_ff <= '0;
    end else if (clk_en) begin
      div_ff <= div_ff + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tick_ff <= 1'b0;
    end else if (clk_en) begin
      tick_ff <= (sel != SEL_STOP) && ((div_ff & tap_mask(sel)) == tap_mask(sel));
    end
  end

endmodule : refresh_prescaler

/* File: sim/refresh_timer_monitor.sv */
`timescale 1ns/100ps
module refresh_timer_monitor
  import refresh_pkg::*;
(
  input wire logic            core_clk,        // clock
  input wire logic            sys_rst,         // reset
  input wire logic            clk_en,          // enable
  input wire logic            hw_standby_pin,  // standby
  input wire logic            normal_mode,     // 64k mode
  input refresh_pkg::wb_req_t wb_i,            // bus request
  input wire logic [31:0]     wb_dat_o,        // read data
  input wire logic            wb_ack_o,        // ack
  input wire logic            refresh_req,     // refresh request
  input wire logic            refresh_grant,   // grant
  input wire logic            refresh_self_ff, // self refresh
  input wire logic            cas_n_ff,        // column strobe
  input wire logic            ras_n_ff,        // row strobe
  input wire logic            match_interrupt  // irq
);
  // ==========================================================
  // port checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_cas; !cas_n_ff && ras_n_ff; endsequence
  sequence s_ras; !cas_n_ff && !ras_n_ff; endsequence
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack held");
  property p_rst; $fell(sys_rst) |-> ras_n_ff && cas_n_ff && !refresh_req && !match_interrupt; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_hold; refresh_req && !refresh_grant |=> refresh_req; endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_cbr; refresh_req && refresh_grant |=> s_cas ##[1:2] s_ras; endproperty
  a_cbr: assert property (p_cbr) else $error("no refresh cycle");
  property p_first; $fell(ras_n_ff) |-> !$past(cas_n_ff); endproperty
  a_first: assert property (p_first) else $error("row before column");
  property p_len; $fell(ras_n_ff) |-> ##[1:4] (ras_n_ff || refresh_self_ff); endproperty
  a_len: assert property (p_len) else $error("row strobe too long");
  property p_normal; normal_mode [*4] |=> !$rose(refresh_req); endproperty
  a_normal: assert property (p_normal) else $error("refresh in normal mode");
  property p_self; refresh_self_ff |-> s_ras; endproperty
  a_self: assert property (p_self) else $error("self without strobes");
  property p_irq; refresh_req || !ras_n_ff |-> !match_interrupt; endproperty
  a_irq: assert property (p_irq) else $error("irq while refreshing");
endmodule : refresh_timer_monitor

bind refresh_timer refresh_timer_monitor mon (.core_clk, .sys_rst, .clk_en, .hw_standby_pin, .normal_mode,
  .wb_i, .wb_dat_o, .wb_ack_o, .refresh_req, .refresh_grant, .refresh_self_ff, .cas_n_ff, .ras_n_ff,
  .match_interrupt);

/* File: sim/dram_model.sv */
`timescale 1ns/100ps
module dram_model (
  input wire logic core_clk,      // clock
  input wire logic refresh_req,   // request
  input wire logic cas_n_ff,      // column strobe
  input wire logic ras_n_ff,      // row strobe
  input int        delay,         // grant latency
  output logic     refresh_grant, // grant level
  output int       refreshes,     // cycles seen
  output int       gap,           // column to row
  output int       low            // row low length
);
  int   w = 0;
  int   g = 0;
  int   l = 0;
  logic ras_q = 1'h1;
  initial begin
    refresh_grant = 1'h0;
    refreshes = 0;
    gap = 0;
    low = 0;
  end
  // ==========================================================
  // grant after a set latency, capture strobe timing
  always @(posedge core_clk) begin
    w <= refresh_req ? w + 1 : 0;
    refresh_grant <= refresh_req && w >= delay;
    g <= cas_n_ff ? 0 : g + 1;
    l <= ras_n_ff ? 0 : l + 1;
    ras_q <= ras_n_ff;
    if (!ras_n_ff && ras_q) gap <= g;
    if (ras_n_ff && !ras_q) begin
      low <= l;
      refreshes <= refreshes + 1;
    end
  end
endmodule : dram_model

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import refresh_pkg::*;
  logic        core_clk, sys_rst, hw_standby_pin, normal_mode, wb_ack_o, refresh_req, refresh_grant;
  logic        refresh_self_ff, cas_n_ff, ras_n_ff, match_interrupt;
  logic [31:0] wb_dat_o;
  logic [7:0]  q;
  wb_req_t     wb_i;
  int          failures, comparisons, refreshes, gap, low;
  int          cycles = 0;
  int          delay = 3;
  int          dv [8] = '{1, 2, 8, 32, 128, 512, 2048, 4096};

  refresh_timer uut (.core_clk, .sys_rst, .clk_en(1'h1), .hw_standby_pin, .normal_mode, .wb_i, .wb_dat_o,
    .wb_ack_o, .refresh_req, .refresh_grant, .refresh_self_ff, .cas_n_ff, .ras_n_ff, .match_interrupt);
  dram_model mem (.core_clk, .refresh_req, .cas_n_ff, .ras_n_ff, .delay, .refresh_grant, .refreshes, .gap, .low);

  // ==========================================================
  // bus and check tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    wb_i <= '{1'h1, 1'h1, w, a, 4'hF, {24'h0, d}};
    do @(posedge core_clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o[7:0];
    wb_i <= '0;
    @(posedge core_clk);
  endtask : wb
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'h0, a, 8'h00);
    check(q, e);
  endtask : rd

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_PERIOD, 8'hFF);
    wr(4'h2, 8'h5A);
    rd(4'h2, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_count();
    logic [7:0] a;
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CONTROL, 8'(s));
      wb(1'h0, ADDR_COUNT, 8'h00);
      a = q;
      cyc(4 * dv[s] - 3);
      wb(1'h0, ADDR_COUNT, 8'h00);
      check(q - a, s == 0 ? 8'h00 : 8'h04);
    end
    $display("test count done");
  endtask : t_count
  task automatic t_match();
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_PERIOD, 8'h03);
    wr(ADDR_CONTROL, 8'h09);
    cyc(30);
    check(match_interrupt, 1'h1);
    wr(ADDR_CONTROL, 8'h00);
    cyc(2);
    check(match_interrupt, 1'h0);
    rd(ADDR_CONTROL, 8'h10);
    wr(ADDR_CONTROL, 8'h08);
    cyc(2);
    check(match_interrupt, 1'h0);
    rd(ADDR_CONTROL, 8'h08);
    wr(ADDR_CONTROL, 8'h00);
    $display("test match done");
  endtask : t_match
  task automatic t_refresh();
    int a;
    wr(ADDR_WAIT, 8'h02);
    wr(ADDR_PERIOD, 8'h0F);
    wr(ADDR_CONTROL, 8'h99);
    wb(1'h0, ADDR_CONTROL, 8'h00);
    check(q & 8'hE8, 8'h80);
    cyc(80);
    check(8'(gap), 8'h01);
    check(8'(low), 8'h03);
    a = refreshes;
    cyc(320);
    check(8'(refreshes - a), 8'h0A);
    delay <= 0;
    wr(ADDR_WAIT, 8'h00);
    wr(ADDR_CONTROL, 8'hD1);
    cyc(80);
    check(8'(gap), 8'h02);
    check(8'(low), 8'h01);
    normal_mode <= 1'h1;
    cyc(40);
    a = refreshes;
    cyc(200);
    check(8'(refreshes - a), 8'h00);
    normal_mode <= 1'h0;
    wr(ADDR_CONTROL, 8'hB1);
    cyc(80);
    check(refresh_self_ff, 1'h1);
    wr(ADDR_CONTROL, 8'h10);
    cyc(4);
    check(ras_n_ff, 1'h1);
    $display("test refresh done");
  endtask : t_refresh
  task automatic t_standby();
    wr(ADDR_PERIOD, 8'h55);
    wr(ADDR_COUNT, 8'h33);
    hw_standby_pin <= 1'h1;
    cyc(6);
    hw_standby_pin <= 1'h0;
    cyc(6);
    rd(ADDR_PERIOD, 8'hFF);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    $display("test standby done");
  endtask : t_standby
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // clock, timeout, main sequence
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    sys_rst = 1'h1;
    hw_standby_pin = 1'h0;
    normal_mode = 1'h0;
    wb_i = '0;
    failures = 0;
    comparisons = 0;
    cyc(8);
    sys_rst <= 1'h0;
    cyc(1);
    t_reset();
    t_count();
    t_match();
    t_refresh();
    t_standby();
    tally_and_finish();
  end
endmodule : tb_top
